// ### hdl/fcr_map.svh
`ifndef FCR_MAP_SVH
`define FCR_MAP_SVH

// Register indices; byte address is four times the index
`define FCR_IDX_A_TAP8      14'h0427
`define FCR_IDX_A_TAP9      14'h0429
`define FCR_IDX_B_TAP1      14'h0448
`define FCR_IDX_B_TAP2      14'h044A
`define FCR_IDX_B_TAP3      14'h044C
`define FCR_IDX_CHAN_MODE   14'h0460
`define FCR_IDX_UPD_STATUS  14'h0461

// Field positions
`define FCR_COEFF_MSB       11
`define FCR_COEFF_LSB       0
`define FCR_RESV_MSB        15
`define FCR_RESV_LSB        12
`define FCR_MODE_SINGLE_BIT 0

// Reset values
`define FCR_COEFF_RESET     16'h0000
`define FCR_MODE_RESET      1'b0
`define FCR_UPD_RESET       5'h00

`endif

// ### hdl/fcr_pkg.sv
package fcr_pkg;

    typedef logic        [15:0] fcr_word_t;
    typedef logic signed [11:0] fcr_tap_t;

    typedef struct packed {
        logic        sel;
        logic        enable;
        logic        write;
        logic [15:0] addr;
        logic [31:0] wdata;
        logic [3:0]  strb;
    } fcr_apb_req_s;

    typedef struct packed {
        logic [31:0] rdata;
        logic        ready;
        logic        slverr;
    } fcr_apb_rsp_s;

    typedef struct packed {
        fcr_tap_t a_tap8;
        fcr_tap_t a_tap9;
        fcr_tap_t b_tap1;
        fcr_tap_t b_tap2;
        fcr_tap_t b_tap3;
    } fcr_taps_s;

    typedef enum logic [2:0] {
        FCR_SEL_NONE   = 3'b000,
        FCR_SEL_A_TAP8 = 3'b001,
        FCR_SEL_A_TAP9 = 3'b010,
        FCR_SEL_B_TAP1 = 3'b011,
        FCR_SEL_B_TAP2 = 3'b100,
        FCR_SEL_B_TAP3 = 3'b101,
        FCR_SEL_MODE   = 3'b110,
        FCR_SEL_STATUS = 3'b111
    } fcr_sel_e;

    typedef enum logic [1:0] {
        FCR_APB_IDLE = 2'b00,
        FCR_APB_RESP = 2'b01
    } fcr_apb_state_e;

endpackage

// ### hdl/fcr_coeff_reg.sv
`timescale 1ns/1ps
`include "fcr_map.svh"

module fcr_coeff_reg
    import fcr_pkg::*;
(
    input  wire logic      clk_i,
    input  wire logic      rst_i,
    input  wire logic      we_i,
    input  wire logic [1:0] strb_i,
    input  wire fcr_word_t wdata_i,
    output fcr_word_t      value_o,
    output fcr_word_t      rdback_o
);

    fcr_word_t value;
    fcr_word_t next_value;

    always_comb begin
        next_value = value;
        if (we_i) begin
            if (strb_i[0]) begin
                next_value[7:0] = wdata_i[7:0];
            end
            if (strb_i[1]) begin
                next_value[15:8] = wdata_i[15:8];
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            value <= `FCR_COEFF_RESET;
        end else begin
            value <= next_value;
        end
    end

    assign value_o = value;

    // Sign bit reads back as zero; the filter still sees the stored bit
    always_comb begin
        rdback_o = value;
        rdback_o[`FCR_COEFF_MSB] = 1'b0;
    end

endmodule // fcr_coeff_reg

// ### hdl/fcr_apb_slave.sv
`timescale 1ns/1ps

module fcr_apb_slave
    import fcr_pkg::*;
(
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire fcr_apb_req_s req_i,
    input  wire logic [31:0]  rd_data_i,
    input  wire logic         hit_i,
    output logic              wr_pulse_o,
    output logic              rd_pulse_o,
    output fcr_apb_rsp_s      rsp_o
);

    fcr_apb_state_e state;
    fcr_apb_state_e next_state;
    fcr_apb_rsp_s   rsp;
    fcr_apb_rsp_s   next_rsp;
    logic           access;

    assign access = req_i.sel & req_i.enable;

    // One wait state: read data captured in the first access cycle
    always_comb begin
        next_state = state;
        next_rsp   = rsp;
        wr_pulse_o = 1'b0;
        rd_pulse_o = 1'b0;
        case (state)
            FCR_APB_IDLE: begin
                next_rsp.ready  = 1'b0;
                next_rsp.slverr = 1'b0;
                if (access) begin
                    next_state      = FCR_APB_RESP;
                    next_rsp.ready  = 1'b1;
                    next_rsp.slverr = ~hit_i;
                    next_rsp.rdata  = (hit_i && !req_i.write) ? rd_data_i : 32'h00000000;
                end
            end
            FCR_APB_RESP: begin
                next_state      = FCR_APB_IDLE;
                next_rsp.ready  = 1'b0;
                next_rsp.slverr = 1'b0;
                if (access) begin
                    wr_pulse_o = req_i.write & hit_i;
                    rd_pulse_o = ~req_i.write & hit_i;
                end
            end
            default: begin
                next_state = FCR_APB_IDLE;
                next_rsp   = '0;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= FCR_APB_IDLE;
            rsp   <= '0;
        end else begin
            state <= next_state;
            rsp   <= next_rsp;
        end
    end

    assign rsp_o = rsp;

endmodule // fcr_apb_slave

// ### hdl/fcr_top.sv
// Function
// - Each coefficient register keeps its tap weight in bits 11:0 as a signed two's complement number.
// - Bits 15:12 of each coefficient register are plain read/write storage that resets to zero.
// - A software read returns bit 11 of the coefficient as zero while the filter uses the full value.
// - Index 0x427 feeds the eighth tap of filter A in dual mode and of the single filter in single mode.
// - Index 0x429 feeds the ninth and last tap of filter A in dual mode and of the single filter in single mode.
// - Index 0x448 feeds the first tap of filter B, used only in dual mode.
// - Index 0x44A feeds the second tap of filter B in dual mode.
// - Index 0x44C feeds the third tap of filter B in dual mode.
// - Every coefficient register resets to zero so its tap starts with zero weight.
// - Each filter has nine taps, the fifth an 18-bit centre tap and the others 12-bit.
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "fcr_map.svh"

module fcr_top
    import fcr_pkg::*;
(
    input  wire logic        CLOCK_I,
    input  wire logic        RST_I,
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [15:0] PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    input  wire logic [3:0]  PSTRB_I,
    output logic      [31:0] PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    output logic             SINGLE_MODE_O,
    output fcr_tap_t         FILT_A_TAP8_O,
    output fcr_tap_t         FILT_A_TAP9_O,
    output fcr_tap_t         FILT_B_TAP1_O,
    output fcr_tap_t         FILT_B_TAP2_O,
    output fcr_tap_t         FILT_B_TAP3_O
);

    localparam int NUM_COEFF = 5;

    fcr_apb_req_s req;
    fcr_apb_rsp_s rsp;
    fcr_sel_e     sel;
    logic         hit;
    logic         wr_pulse;
    logic         rd_pulse;
    logic [31:0]  rd_data;

    fcr_word_t    coeff_val    [NUM_COEFF];
    fcr_word_t    coeff_rdback [NUM_COEFF];
    logic         coeff_we     [NUM_COEFF];

    logic         single_mode;
    logic         next_single_mode;
    logic [4:0]   upd_status;
    logic [4:0]   next_upd_status;

    fcr_taps_s    taps;
    fcr_taps_s    next_taps;

    // Byte address is index times four; misaligned addresses do not hit
    function automatic fcr_sel_e decode_addr(input logic [15:0] addr);
        fcr_sel_e s;
        s = FCR_SEL_NONE;
        if (addr[1:0] == 2'b00) begin
            case (addr[15:2])
                `FCR_IDX_A_TAP8:     s = FCR_SEL_A_TAP8;
                `FCR_IDX_A_TAP9:     s = FCR_SEL_A_TAP9;
                `FCR_IDX_B_TAP1:     s = FCR_SEL_B_TAP1;
                `FCR_IDX_B_TAP2:     s = FCR_SEL_B_TAP2;
                `FCR_IDX_B_TAP3:     s = FCR_SEL_B_TAP3;
                `FCR_IDX_CHAN_MODE:  s = FCR_SEL_MODE;
                `FCR_IDX_UPD_STATUS: s = FCR_SEL_STATUS;
                default:             s = FCR_SEL_NONE;
            endcase
        end
        return s;
    endfunction

    // Slot of a coefficient register in the storage array
    function automatic logic [2:0] coeff_slot(input fcr_sel_e s);
        logic [2:0] n;
        case (s)
            FCR_SEL_A_TAP8: n = 3'h0;
            FCR_SEL_A_TAP9: n = 3'h1;
            FCR_SEL_B_TAP1: n = 3'h2;
            FCR_SEL_B_TAP2: n = 3'h3;
            FCR_SEL_B_TAP3: n = 3'h4;
            default:        n = 3'h7;
        endcase
        return n;
    endfunction

    // Low twelve bits as a signed tap weight
    function automatic fcr_tap_t tap_of(input fcr_word_t w);
        return fcr_tap_t'(w[`FCR_COEFF_MSB:`FCR_COEFF_LSB]);
    endfunction

    always_comb begin
        req.sel    = PSEL_I;
        req.enable = PENABLE_I;
        req.write  = PWRITE_I;
        req.addr   = PADDR_I;
        req.wdata  = PWDATA_I;
        req.strb   = PSTRB_I;
    end

    assign sel = decode_addr(PADDR_I);
    assign hit = (sel != FCR_SEL_NONE);

    fcr_apb_slave u_apb (
        .clk_i      (CLOCK_I),
        .rst_i      (RST_I),
        .req_i      (req),
        .rd_data_i  (rd_data),
        .hit_i      (hit),
        .wr_pulse_o (wr_pulse),
        .rd_pulse_o (rd_pulse),
        .rsp_o      (rsp)
    );

    always_comb begin
        for (int i = 0; i < NUM_COEFF; i++) begin
            coeff_we[i] = wr_pulse && (coeff_slot(sel) == 3'(i));
        end
    end

    for (genvar g = 0; g < NUM_COEFF; g++) begin : g_coeff
        fcr_coeff_reg u_reg (
            .clk_i    (CLOCK_I),
            .rst_i    (RST_I),
            .we_i     (coeff_we[g]),
            .strb_i   (PSTRB_I[1:0]),
            .wdata_i  (PWDATA_I[15:0]),
            .value_o  (coeff_val[g]),
            .rdback_o (coeff_rdback[g])
        );
    end

    // Read mux; bits above the 16-bit register read as zero
    always_comb begin
        rd_data = 32'h00000000;
        case (sel)
            FCR_SEL_A_TAP8: rd_data[15:0] = coeff_rdback[0];
            FCR_SEL_A_TAP9: rd_data[15:0] = coeff_rdback[1];
            FCR_SEL_B_TAP1: rd_data[15:0] = coeff_rdback[2];
            FCR_SEL_B_TAP2: rd_data[15:0] = coeff_rdback[3];
            FCR_SEL_B_TAP3: rd_data[15:0] = coeff_rdback[4];
            FCR_SEL_MODE:   rd_data[`FCR_MODE_SINGLE_BIT] = single_mode;
            FCR_SEL_STATUS: rd_data[4:0] = upd_status;
            default:        rd_data = 32'h00000000;
        endcase
    end

    // Channel mode and sticky update flags; a new write beats clear-on-read
    always_comb begin
        next_single_mode = single_mode;
        next_upd_status  = upd_status;
        if (wr_pulse && sel == FCR_SEL_MODE && PSTRB_I[0]) begin
            next_single_mode = PWDATA_I[`FCR_MODE_SINGLE_BIT];
        end
        if (rd_pulse && sel == FCR_SEL_STATUS) begin
            next_upd_status = 5'h00;
        end
        for (int i = 0; i < NUM_COEFF; i++) begin
            if (coeff_we[i]) begin
                next_upd_status[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            single_mode <= `FCR_MODE_RESET;
            upd_status  <= `FCR_UPD_RESET;
        end else begin
            single_mode <= next_single_mode;
            upd_status  <= next_upd_status;
        end
    end

    // Tap outputs registered; filter B held at zero weight in single mode
    always_comb begin
        next_taps.a_tap8 = tap_of(coeff_val[0]);
        next_taps.a_tap9 = tap_of(coeff_val[1]);
        next_taps.b_tap1 = tap_of(coeff_val[2]);
        next_taps.b_tap2 = tap_of(coeff_val[3]);
        next_taps.b_tap3 = tap_of(coeff_val[4]);
        if (single_mode) begin
            next_taps.b_tap1 = '0;
            next_taps.b_tap2 = '0;
            next_taps.b_tap3 = '0;
        end
    end

    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            taps <= '0;
        end else begin
            taps <= next_taps;
        end
    end

    assign PRDATA_O      = rsp.rdata;
    assign PREADY_O      = rsp.ready;
    assign PSLVERR_O     = rsp.slverr;
    assign SINGLE_MODE_O = single_mode;
    assign FILT_A_TAP8_O = taps.a_tap8;
    assign FILT_A_TAP9_O = taps.a_tap9;
    assign FILT_B_TAP1_O = taps.b_tap1;
    assign FILT_B_TAP2_O = taps.b_tap2;
    assign FILT_B_TAP3_O = taps.b_tap3;

endmodule // fcr_top

// ### bench/fcr_chk.sv
`timescale 1ns/1ps

module fcr_chk
    import fcr_pkg::*;
(
    input wire logic        CLOCK_I,
    input wire logic        RST_I,
    input wire logic        PSEL_I,
    input wire logic        PENABLE_I,
    input wire logic        PWRITE_I,
    input wire logic [15:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [3:0]  PSTRB_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic        PREADY_O,
    input wire logic        PSLVERR_O,
    input wire logic        SINGLE_MODE_O,
    input wire fcr_tap_t    FILT_A_TAP8_O,
    input wire fcr_tap_t    FILT_A_TAP9_O,
    input wire fcr_tap_t    FILT_B_TAP1_O,
    input wire fcr_tap_t    FILT_B_TAP2_O,
    input wire fcr_tap_t    FILT_B_TAP3_O
);
    wire logic coeff  = PADDR_I inside {16'h109C, 16'h10A4, 16'h1120, 16'h1128, 16'h1130};
    wire logic mapped = coeff || PADDR_I inside {16'h1180, 16'h1184};
    wire logic wr_ok  = PREADY_O && PWRITE_I && PSTRB_I == 4'hF && !PSLVERR_O;
    wire logic a8_wr  = wr_ok && PADDR_I == 16'h109C;
    wire logic b1_wr  = wr_ok && PADDR_I == 16'h1120 && !SINGLE_MODE_O;
    wire logic b_zero = {FILT_B_TAP1_O, FILT_B_TAP2_O, FILT_B_TAP3_O} == 36'h0;

    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (RST_I);

    chk_ready_delay: assert property (PSEL_I && !PENABLE_I |-> ##2 PREADY_O)
        else $error("ready late");
    chk_ready_pulse: assert property (PREADY_O |=> !PREADY_O)
        else $error("ready too long");
    chk_ready_cause: assert property (PREADY_O |-> $past(PSEL_I && PENABLE_I))
        else $error("ready without access");
    chk_err_decode: assert property (PREADY_O |-> PSLVERR_O == !mapped)
        else $error("error flag wrong");
    chk_err_zero: assert property (PREADY_O && PSLVERR_O |-> PRDATA_O == 32'h0)
        else $error("refused read not zero");
    chk_upper_zero: assert property (PREADY_O && !PWRITE_I |-> PRDATA_O[31:16] == 16'h0)
        else $error("upper read bits set");
    chk_msb_hidden: assert property (PREADY_O && !PWRITE_I && coeff |-> !PRDATA_O[11])
        else $error("sign bit visible");
    chk_tap_update: assert property (a8_wr |-> ##2 FILT_A_TAP8_O == $past(PWDATA_I[11:0], 2))
        else $error("tap8 not updated");
    chk_b_update: assert property (b1_wr |-> ##2 FILT_B_TAP1_O == $past(PWDATA_I[11:0], 2))
        else $error("b tap1 not updated");
    chk_single_b: assert property (SINGLE_MODE_O && $past(SINGLE_MODE_O) |-> b_zero)
        else $error("b taps live in single mode");

    cover property (PREADY_O && PSLVERR_O);
    cover property (wr_ok && coeff);
    cover property (SINGLE_MODE_O && PREADY_O && !PWRITE_I);
endmodule // fcr_chk

bind fcr_top fcr_chk chk_u (.CLOCK_I(CLOCK_I), .RST_I(RST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
    .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PSTRB_I(PSTRB_I), .PRDATA_O(PRDATA_O),
    .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .SINGLE_MODE_O(SINGLE_MODE_O), .FILT_A_TAP8_O(FILT_A_TAP8_O),
    .FILT_A_TAP9_O(FILT_A_TAP9_O), .FILT_B_TAP1_O(FILT_B_TAP1_O), .FILT_B_TAP2_O(FILT_B_TAP2_O),
    .FILT_B_TAP3_O(FILT_B_TAP3_O));

// ### bench/fcr_tb.sv
`timescale 1ns/1ps

module tb
    import fcr_pkg::*;
;
    logic        clk  = 1'b0;
    logic        rst  = 1'b1;
    logic        psel = 1'b0;
    logic        pen  = 1'b0;
    logic        pwr  = 1'b0;
    logic [15:0] padr = 16'h0;
    logic [31:0] pwd  = 32'h0;
    logic [3:0]  pstb = 4'h0;
    wire  [31:0] prd;
    wire         prdy;
    wire         perr;
    wire         single;
    wire fcr_tap_t tap [5];
    int          bad_count   = 0;
    int          check_count = 0;
    logic [15:0] adr [5] = '{16'h109C, 16'h10A4, 16'h1120, 16'h1128, 16'h1130};
    logic [15:0] val [5] = '{16'hFABC, 16'h1801, 16'h2955, 16'h3AAA, 16'hC8F0};
    logic [31:0] r;
    logic        e;

    fcr_top dut_u (.CLOCK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(padr),
        .PWDATA_I(pwd), .PSTRB_I(pstb), .PRDATA_O(prd), .PREADY_O(prdy), .PSLVERR_O(perr),
        .SINGLE_MODE_O(single), .FILT_A_TAP8_O(tap[0]), .FILT_A_TAP9_O(tap[1]), .FILT_B_TAP1_O(tap[2]),
        .FILT_B_TAP2_O(tap[3]), .FILT_B_TAP3_O(tap[4]));

    always #20 clk = ~clk;

    task end_sim;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task chk(input logic [31:0] g, input logic [31:0] x, input string m);
        check_count++;
        if (g !== x) begin
            bad_count++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask

    // Request stands until ready is seen high at a rising edge; only the watchdog ends a hang
    task apb(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge clk);
        psel <= 1'b1;
        pwr  <= w;
        padr <= a;
        pwd  <= d;
        pstb <= s;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
        end while (prdy !== 1'b1);
        r = prd;
        e = perr;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask

    task rd(input logic [15:0] a, input logic [31:0] x, input logic xe);
        apb(1'b0, a, 32'h0, 4'hF);
        chk(r, x, "read data");
        chk({31'h0, e}, {31'h0, xe}, "error flag");
    endtask

    // Extra cycle allows for the tap stage behind the mode register
    task chk_taps(input logic sm);
        repeat (2) @(negedge clk);
        for (int i = 0; i < 5; i++)
            chk({20'h0, tap[i]}, (sm && i > 1) ? 32'h0 : {20'h0, val[i][11:0]}, "tap port");
    endtask

    task t_reset;
        for (int i = 0; i < 5; i++) rd(adr[i], 32'h0, 1'b0);
        rd(16'h1180, 32'h0, 1'b0);
        rd(16'h1184, 32'h0, 1'b0);
        for (int i = 0; i < 5; i++) chk({20'h0, tap[i]}, 32'h0, "tap reset");
        $display("test reset done");
    endtask

    task t_write;
        for (int i = 0; i < 5; i++) apb(1'b1, adr[i], {16'hFFFF, val[i]}, 4'hF);
        for (int i = 0; i < 5; i++) rd(adr[i], {16'h0, val[i] & 16'hF7FF}, 1'b0);
        chk_taps(1'b0);
        rd(16'h1184, 32'h1F, 1'b0);
        rd(16'h1184, 32'h0, 1'b0);
        $display("test write done");
    endtask

    task t_strobe;
        apb(1'b1, adr[1], 32'h0, 4'h2);
        val[1] = 16'h0001;
        rd(adr[1], 32'h1, 1'b0);
        chk_taps(1'b0);
        $display("test strobe done");
    endtask

    task t_single;
        apb(1'b1, 16'h1180, 32'h1, 4'hF);
        chk_taps(1'b1);
        chk({31'h0, single}, 32'h1, "mode");
        apb(1'b1, adr[2], 32'h0123, 4'hF);
        val[2] = 16'h0123;
        rd(adr[2], 32'h0123, 1'b0);
        chk_taps(1'b1);
        apb(1'b1, 16'h1180, 32'h0, 4'hF);
        chk_taps(1'b0);
        $display("test single done");
    endtask

    // Misaligned and neighbouring words must leave stored taps alone
    task t_error;
        apb(1'b1, 16'h109E, 32'h0, 4'hF);
        chk({31'h0, e}, 32'h1, "misaligned");
        apb(1'b1, 16'h1098, 32'h0, 4'hF);
        chk({31'h0, e}, 32'h1, "neighbour");
        rd(16'h1000, 32'h0, 1'b1);
        rd(adr[0], {16'h0, val[0] & 16'hF7FF}, 1'b0);
        $display("test error done");
    endtask

    task t_rst;
        apb(1'b1, 16'h1180, 32'h1, 4'hF);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        $display("test mid reset done");
    endtask

    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_write();
        t_strobe();
        t_single();
        t_error();
        t_rst();
        end_sim();
    end

    initial begin
        repeat (3000) @(posedge clk);
        chk(0, 1, "timeout");
        end_sim();
    end
endmodule // tb
